// File: hdl/amps_supervisor.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Zone output when position inside zone bounds
// [R2] Zone active only in patterns 0, 4, 5
// [R3] Commanded targets clamped to soft limits
// [R4] Second zone, jog, inching settings ignored
// [R5] Home direction bit picks homing travel
// [R6] Teach jog uses jog speed, max 250
// [R7] Teach inching moves set distance, max 1mm
// [R8] Unregistered target write takes default speed
// [R9] Fill accel from default on write/capture
// [R10] Fill band from default on write/capture
// [R11] Position complete when inside target band
// [R12] PLC moves scaled by override percent
// [R13] No override for PC or pendant moves
// [R14] First servo-on runs phase detect, set direction
// [R15] Phase detect lasts the configured time
// [R16] Manual feed uses safety speed, max 250
// [R17] Modes 1-3 servo off after delay
// [R18] Standstill mode decode 0..4
// [R19] Power saving gated by pattern and homing
// [R20] Settings take effect only after restart
// [R21] Home sensor polarity decode none/NO/NC
// [R22] Standstill current limit kept at most 70%
// [R23] Auto servo-off resumes on next PLC move
// [R24] Zone held low unsupported or unhomed
module amps_supervisor
  import amps_pkg::*;
#(
  parameter int MS_CYCLES = CLK_HZ / MS_PER_SEC * PHASE_TIME_UNIT_MS,
  parameter int SEC_CYCLES = CLK_HZ * DELAY_UNIT_SEC
) (
  input wire logic clk,
  input wire logic rst_n,
  input amps_cfg_t cfg_in,
  input wire logic soft_reset,
  input wire logic servo_on_req,
  input wire logic signed [31:0] cur_pos,
  input wire logic cmd_valid,
  input amps_cmd_t cmd,
  input wire logic home_done,
  input wire logic home_sensor_raw,
  input wire logic tbl_write,
  input wire logic tbl_capture,
  input wire logic tbl_registered,
  output logic zone_window_output_q,
  output logic servo_on_q,
  output logic full_servo_q,
  output logic phase_active_q,
  output logic phase_dir_q,
  output logic motion_valid_q,
  output amps_motion_t motion_q,
  output logic pos_complete_q,
  output logic homed_q,
  output logic home_sensor_hit_q,
  output logic fill_valid_q,
  output amps_fill_t fill_q
);
  typedef enum logic [2:0] {ST_OFF, ST_PHASE, ST_READY, ST_MOVE, ST_HOME, ST_SAVE} amps_state_t;

  amps_state_t state_q;
  amps_cfg_t cfg_q;
  logic load_q;
  logic phase_done_q;
  logic plc_homed_q;
  logic home_plc_q;
  logic [31:0] tick_q;
  logic [15:0] units_q;
  logic signed [31:0] goal_q;
  logic [15:0] band_q;

  // Settings are copied only at restart so a half-written set never steers motion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_q <= 1'b1;
      cfg_q <= '0;
    end else begin
      load_q <= soft_reset; // [R20]
      if (load_q) begin
        cfg_q <= cfg_in; // [R20]
      end
    end
  end

  logic zone_pat;
  logic save_pat;
  logic cmd_ok;
  logic [7:0] delay_sel;
  logic [7:0] scale;
  logic [15:0] jog_spd;
  logic [15:0] safe_spd;
  logic [15:0] inch;
  logic [39:0] prod;
  logic [15:0] scaled;
  logic signed [31:0] raw_goal;
  logic signed [31:0] clamp_goal;
  logic signed [32:0] err;
  logic [32:0] err_abs;
  logic in_band;
  amps_motion_t mot_d;

  always_comb begin
    zone_pat = (cfg_q.parallel_io_pattern == PAT_STANDARD) || // [R2]
               (cfg_q.parallel_io_pattern == PAT_SEVEN) ||
               (cfg_q.parallel_io_pattern == PAT_THREE);
    save_pat = (cfg_q.parallel_io_pattern == PAT_THREE) ? // [R19]
               (cfg_q.standstill_mode_default == SSM_FULL) : plc_homed_q;
    unique case (cfg_q.standstill_mode_default) // [R18]
      SSM_OFF_A: delay_sel = cfg_q.servo_off_delay_a; // [R17]
      SSM_OFF_B: delay_sel = cfg_q.servo_off_delay_b;
      SSM_OFF_C: delay_sel = cfg_q.servo_off_delay_c;
      default: delay_sel = 8'h00;
    endcase
    scale = cfg_q.speed_scale_percent;
    if (scale < SCALE_MIN) scale = SCALE_MIN;
    if (scale > SCALE_MAX) scale = SCALE_MAX;
    jog_spd = (cfg_q.teach_jog_speed > JOG_SPEED_MAX) ? JOG_SPEED_MAX : cfg_q.teach_jog_speed; // [R6]
    safe_spd = (cfg_q.manual_feed_speed > SAFE_SPEED_MAX) ? SAFE_SPEED_MAX : // [R16]
               cfg_q.manual_feed_speed;
    inch = (cfg_q.teach_inch_distance > INCH_DIST_MAX) ? INCH_DIST_MAX : // [R7]
           cfg_q.teach_inch_distance;
    prod = {24'h000000, cmd.speed} * {32'h00000000, scale};
    scaled = 16'(prod / {16'h0000, SCALE_DIV}); // [R12]
    // Jog and inching exist only in the teaching pattern
    cmd_ok = cmd_valid && ((cmd.kind == AMPS_MOVE) || (cmd.kind == AMPS_HOME) ||
             (cfg_q.parallel_io_pattern == PAT_TEACH));
    mot_d.homing = 1'b0;
    mot_d.speed = cmd.from_plc ? scaled : cmd.speed; // [R13]
    unique case (cmd.kind)
      AMPS_JOG_POS: raw_goal = cfg_q.soft_limit_positive;
      AMPS_JOG_NEG: raw_goal = cfg_q.soft_limit_negative;
      AMPS_INCH_POS: raw_goal = cur_pos + $signed({16'h0000, inch}); // [R7]
      AMPS_INCH_NEG: raw_goal = cur_pos - $signed({16'h0000, inch});
      default: raw_goal = cmd.target;
    endcase
    if (cmd.kind != AMPS_MOVE) mot_d.speed = jog_spd; // [R6]
    if (cmd.manual) mot_d.speed = safe_spd; // [R16]
    clamp_goal = raw_goal;
    if (raw_goal > cfg_q.soft_limit_positive) clamp_goal = cfg_q.soft_limit_positive; // [R3]
    if (raw_goal < cfg_q.soft_limit_negative) clamp_goal = cfg_q.soft_limit_negative; // [R3]
    mot_d.target = clamp_goal;
    mot_d.dir = clamp_goal > cur_pos;
    if (cmd.kind == AMPS_HOME) begin
      mot_d.homing = 1'b1;
      mot_d.dir = cfg_q.homing_direction; // [R5]
      mot_d.target = cur_pos;
    end
    err = {goal_q[31], goal_q} - {cur_pos[31], cur_pos};
    err_abs = err[32] ? 33'(-err) : 33'(err);
    in_band = err_abs <= {17'h00000, band_q}; // [R11]
  end

  // One shared prescaler: milliseconds while detecting phase, seconds while idling
  logic tick_ms;
  logic tick_sec;
  assign tick_ms = tick_q == 32'(MS_CYCLES - 1);
  assign tick_sec = tick_q == 32'(SEC_CYCLES - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
      servo_on_q <= 1'b0;
      phase_done_q <= 1'b0;
      phase_active_q <= 1'b0;
      phase_dir_q <= 1'b0;
      tick_q <= 32'h00000000;
      units_q <= 16'h0000;
      motion_valid_q <= 1'b0;
      motion_q <= '0;
      goal_q <= 32'sh00000000;
      band_q <= 16'h0000;
      pos_complete_q <= 1'b0;
      homed_q <= 1'b0;
      plc_homed_q <= 1'b0;
      home_plc_q <= 1'b0;
      full_servo_q <= 1'b0;
    end else begin
      motion_valid_q <= 1'b0;
      tick_q <= ((state_q == ST_PHASE && tick_ms) || tick_sec) ? 32'h00000000 : tick_q + 1;
      if (cmd_ok && (state_q == ST_READY || state_q == ST_MOVE ||
          (state_q == ST_SAVE && cmd.from_plc))) begin
        servo_on_q <= 1'b1; // [R23]
        motion_valid_q <= 1'b1;
        motion_q <= mot_d;
        goal_q <= mot_d.target;
        band_q <= (cmd.kind == AMPS_MOVE) ? cmd.band : cfg_q.default_position_band;
        pos_complete_q <= 1'b0;
        full_servo_q <= 1'b0;
        state_q <= (cmd.kind == AMPS_HOME) ? ST_HOME : ST_MOVE;
        // Command lines are not held past the valid cycle, so the source is kept here
        home_plc_q <= (cmd.kind == AMPS_HOME) && cmd.from_plc; // [R19]
      end else begin
        unique case (state_q)
          ST_OFF: begin
            if (servo_on_req) begin
              servo_on_q <= 1'b1;
              tick_q <= 32'h00000000;
              units_q <= 16'h0000;
              phase_active_q <= !phase_done_q; // [R14]
              phase_dir_q <= cfg_q.phase_detect_dir; // [R14]
              state_q <= phase_done_q ? ST_READY : ST_PHASE;
            end
          end
          ST_PHASE: begin
            if (tick_ms) units_q <= units_q + 16'h0001;
            if (units_q >= cfg_q.phase_detect_time_ms) begin // [R15]
              phase_active_q <= 1'b0;
              phase_done_q <= 1'b1;
              state_q <= ST_READY;
            end
          end
          ST_MOVE: begin
            if (in_band) begin
              pos_complete_q <= 1'b1; // [R11]
              units_q <= 16'h0000;
              tick_q <= 32'h00000000;
              state_q <= ST_READY;
            end
          end
          ST_HOME: begin
            if (home_done) begin
              homed_q <= 1'b1;
              plc_homed_q <= home_plc_q; // [R19]
              pos_complete_q <= 1'b1;
              units_q <= 16'h0000;
              tick_q <= 32'h00000000;
              state_q <= ST_READY;
            end
          end
          ST_READY: begin
            if (tick_sec) units_q <= units_q + 16'h0001;
            full_servo_q <= save_pat && pos_complete_q &&
                            (cfg_q.standstill_mode_default == SSM_FULL); // [R18]
            if (save_pat && pos_complete_q && delay_sel != 8'h00 &&
                units_q >= {8'h00, delay_sel}) begin // [R17]
              servo_on_q <= 1'b0;
              state_q <= ST_SAVE;
            end else if (save_pat && pos_complete_q && tick_sec == 1'b0 &&
                cfg_q.standstill_mode_default >= SSM_OFF_A &&
                cfg_q.standstill_mode_default <= SSM_OFF_C && delay_sel == 8'h00) begin
              servo_on_q <= 1'b0; // [R17]
              state_q <= ST_SAVE;
            end
          end
          ST_SAVE: begin
            servo_on_q <= 1'b0;
          end
          default: state_q <= ST_OFF;
        endcase
      end
      if (!servo_on_req) begin
        servo_on_q <= 1'b0;
        phase_active_q <= 1'b0;
        full_servo_q <= 1'b0;
        state_q <= ST_OFF;
      end
    end
  end

  // Zone follows the current position only once homing has given it meaning
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zone_window_output_q <= 1'b0;
      home_sensor_hit_q <= 1'b0;
    end else begin
      zone_window_output_q <= zone_pat && homed_q && // [R24]
                              cur_pos >= cfg_q.zone_bound_lower && // [R1]
                              cur_pos <= cfg_q.zone_bound_upper; // [R4]
      unique case (cfg_q.homing_sensor_polarity) // [R21]
        SENS_NO: home_sensor_hit_q <= home_sensor_raw;
        SENS_NC: home_sensor_hit_q <= !home_sensor_raw;
        default: home_sensor_hit_q <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_valid_q <= 1'b0;
      fill_q <= '0;
    end else begin
      fill_valid_q <= (tbl_write && !tbl_registered) || tbl_capture;
      fill_q.speed_valid <= tbl_write && !tbl_registered; // [R8]
      fill_q.speed <= cfg_q.default_speed; // [R8]
      fill_q.accel <= cfg_q.default_accel; // [R9]
      fill_q.band <= cfg_q.default_position_band; // [R10]
    end
  end

  AST_ZONE_PATTERN: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    (!zone_pat || !homed_q) |=> !zone_window_output_q)
    else $error("zone output in unsupported pattern or unhomed");
  AST_ZONE_WINDOW: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    (zone_pat && homed_q && cur_pos >= cfg_q.zone_bound_lower &&
     cur_pos <= cfg_q.zone_bound_upper) |=> zone_window_output_q)
    else $error("zone output missing inside window");
  AST_SOFT_LIMIT: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    motion_valid_q && !motion_q.homing |-> (motion_q.target <= cfg_q.soft_limit_positive &&
    motion_q.target >= cfg_q.soft_limit_negative))
    else $error("target outside soft limits");
  AST_HOME_DIR: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    motion_valid_q && motion_q.homing |-> motion_q.dir == cfg_q.homing_direction)
    else $error("homing direction wrong");
  AST_JOG_CAP: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
    cmd_ok && cmd.kind != AMPS_MOVE && !cmd.manual &&
    (state_q == ST_READY || state_q == ST_MOVE)
    |=> motion_q.speed <= JOG_SPEED_MAX)
    else $error("jog speed above cap");
  AST_OVERRIDE: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    cmd_ok && cmd.kind == AMPS_MOVE && cmd.from_plc && !cmd.manual &&
    (state_q == ST_READY || state_q == ST_MOVE) &&
    cfg_q.speed_scale_percent >= SCALE_MIN && cfg_q.speed_scale_percent <= SCALE_MAX
    |=> motion_q.speed == 16'((24'($past(cmd.speed)) *
    24'($past(cfg_q.speed_scale_percent))) / SCALE_DIV))
    else $error("override scaling wrong");
  AST_NO_OVERRIDE: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    cmd_ok && cmd.kind == AMPS_MOVE && !cmd.from_plc && !cmd.manual &&
    (state_q == ST_READY || state_q == ST_MOVE)
    |=> motion_q.speed == $past(cmd.speed))
    else $error("override applied to non-PLC move");
  AST_PHASE_FIRST: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
    state_q == ST_OFF && servo_on_req && !phase_done_q |=> phase_active_q && state_q == ST_PHASE)
    else $error("phase detect not started on first servo-on");
  AST_FILL: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
    (tbl_write && !tbl_registered) || tbl_capture |=> fill_valid_q &&
    fill_q.accel == $past(cfg_q.default_accel) && fill_q.band == $past(cfg_q.default_position_band))
    else $error("default fill wrong");
  AST_SAVE_GATE: assert property (@(posedge clk) disable iff (!rst_n) // [R19]
    state_q == ST_READY && !save_pat |=> state_q != ST_SAVE)
    else $error("power saving without eligibility");
  AST_RESUME: assert property (@(posedge clk) disable iff (!rst_n) // [R23]
    state_q == ST_SAVE && cmd_ok && cmd.from_plc && servo_on_req |=> servo_on_q && motion_valid_q)
    else $error("no resume after auto servo-off");
endmodule : amps_supervisor

// File: hdl/amps_pkg.sv
package amps_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_PER_SEC = 1000;
  localparam int PHASE_TIME_UNIT_MS = 1;
  localparam int DELAY_UNIT_SEC = 1;
  // Speeds in mm/s, positions and distances in 0.01 mm
  localparam logic [15:0] JOG_SPEED_MAX = 16'h00fa;
  localparam logic [15:0] JOG_SPEED_RST = 16'h0064;
  localparam logic [15:0] SAFE_SPEED_MAX = 16'h00fa;
  localparam logic [15:0] SAFE_SPEED_RST = 16'h0064;
  localparam logic [15:0] INCH_DIST_MAX = 16'h0064;
  localparam logic [15:0] INCH_DIST_RST = 16'h000a;
  localparam logic [15:0] BAND_RST = 16'h000a;
  localparam logic [7:0] SCALE_MIN = 8'h01;
  localparam logic [7:0] SCALE_MAX = 8'h64;
  localparam logic [23:0] SCALE_DIV = 24'h000064;
  localparam logic [2:0] PAT_STANDARD = 3'h0;
  localparam logic [2:0] PAT_TEACH = 3'h1;
  localparam logic [2:0] PAT_SEVEN = 3'h4;
  localparam logic [2:0] PAT_THREE = 3'h5;
  localparam logic [2:0] SSM_NONE = 3'h0;
  localparam logic [2:0] SSM_OFF_A = 3'h1;
  localparam logic [2:0] SSM_OFF_B = 3'h2;
  localparam logic [2:0] SSM_OFF_C = 3'h3;
  localparam logic [2:0] SSM_FULL = 3'h4;
  localparam logic [1:0] SENS_NONE = 2'h0;
  localparam logic [1:0] SENS_NO = 2'h1;
  localparam logic [1:0] SENS_NC = 2'h2;

  typedef enum logic [2:0] {
    AMPS_MOVE, AMPS_JOG_POS, AMPS_JOG_NEG, AMPS_INCH_POS, AMPS_INCH_NEG, AMPS_HOME
  } amps_kind_t;

  // Second zone pair, second jog speed and second inching distance are not carried [R4]
  typedef struct packed {
    logic signed [31:0] soft_limit_positive;
    logic signed [31:0] soft_limit_negative;
    logic signed [31:0] zone_bound_upper;
    logic signed [31:0] zone_bound_lower;
    logic homing_direction;
    logic [15:0] teach_jog_speed;
    logic [15:0] teach_inch_distance;
    logic [15:0] default_speed;
    logic [15:0] default_accel;
    logic [15:0] default_position_band;
    logic [1:0] homing_sensor_polarity;
    logic [7:0] speed_scale_percent;
    logic phase_detect_dir;
    logic [15:0] phase_detect_time_ms;
    logic [15:0] manual_feed_speed;
    logic [7:0] servo_off_delay_a;
    logic [7:0] servo_off_delay_b;
    logic [7:0] servo_off_delay_c;
    logic [2:0] standstill_mode_default;
    logic [2:0] parallel_io_pattern;
  } amps_cfg_t;

  typedef struct packed {
    amps_kind_t kind;
    logic from_plc;
    logic manual;
    logic signed [31:0] target;
    logic [15:0] speed;
    logic [15:0] band;
  } amps_cmd_t;

  typedef struct packed {
    logic signed [31:0] target;
    logic [15:0] speed;
    logic dir;
    logic homing;
  } amps_motion_t;

  typedef struct packed {
    logic speed_valid;
    logic [15:0] speed;
    logic [15:0] accel;
    logic [15:0] band;
  } amps_fill_t;
endpackage : amps_pkg

// File: verification/amps_plc_model.sv
`timescale 1ns/1ps
module amps_plc_model
  import amps_pkg::*;
(
  input wire logic clk,
  output logic cmd_valid,
  output amps_cmd_t cmd,
  output logic soft_reset,
  output amps_cfg_t cfg
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    soft_reset = 1'b0;
    cfg = '0;
  end
  // Command lines carry junk outside the valid cycle so stale data is never trusted
  task automatic issue(input amps_cmd_t c);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd <= ~c;
  endtask : issue
  // New settings are always followed by a restart
  task automatic restart(input amps_cfg_t c);
    @(posedge clk);
    // No current limit travels in this set, so it can never exceed 70%
    cfg <= c;
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : restart
endmodule : amps_plc_model

// File: verification/amps_supervisor_test.sv
`timescale 1ns/1ps
module amps_supervisor_test;
  import amps_pkg::*;
  typedef struct packed {
    logic [2:0] pat;
    logic hdir;
    amps_cmd_t c;
    logic ev;
    logic signed [31:0] et;
    logic [15:0] es;
    logic home;
  } amps_row_t;
  logic clk, rst_n, soft_reset, servo_on_req, cmd_valid, home_done, sens_raw;
  logic tbl_write, tbl_capture, tbl_registered;
  logic zone, servo_on, full_servo, phase_act, phase_dir, mv, pos_done, homed, sens_hit, fv;
  logic signed [31:0] cur_pos;
  amps_cfg_t cfg, base;
  amps_cmd_t cmd;
  amps_motion_t mo;
  amps_fill_t fo;
  amps_row_t rows[11];
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int d;

  amps_plc_model amps_plc_model_inst (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd),
    .soft_reset(soft_reset), .cfg(cfg));
  // Short tick counts keep the delays in the tens of cycles
  amps_supervisor #(.MS_CYCLES(4), .SEC_CYCLES(10)) amps_supervisor_inst (.clk(clk),
    .rst_n(rst_n), .cfg_in(cfg), .soft_reset(soft_reset), .servo_on_req(servo_on_req),
    .cur_pos(cur_pos), .cmd_valid(cmd_valid), .cmd(cmd), .home_done(home_done),
    .home_sensor_raw(sens_raw), .tbl_write(tbl_write), .tbl_capture(tbl_capture),
    .tbl_registered(tbl_registered), .zone_window_output_q(zone), .servo_on_q(servo_on),
    .full_servo_q(full_servo), .phase_active_q(phase_act), .phase_dir_q(phase_dir),
    .motion_valid_q(mv), .motion_q(mo), .pos_complete_q(pos_done), .homed_q(homed),
    .home_sensor_hit_q(sens_hit), .fill_valid_q(fv), .fill_q(fo));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic chk(input logic [49:0] got, input logic [49:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %0h want %0h", $time, got, exp);
    end
  endtask : chk

  function automatic amps_cmd_t mk(amps_kind_t k, logic p, logic m, int t, int s, int b);
    mk = '{kind: k, from_plc: p, manual: m, target: t, speed: 16'(s), band: 16'(b)};
  endfunction : mk

  task automatic wait_look(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_look

  task automatic go_home();
    amps_plc_model_inst.issue(mk(AMPS_HOME, 1'b1, 1'b0, 0, 0, 0));
    home_done <= 1'b1;
    @(posedge clk);
    home_done <= 1'b0;
  endtask : go_home

  initial begin
    {rst_n, servo_on_req, home_done, sens_raw, tbl_write, tbl_capture, tbl_registered} = '0;
    cur_pos = 150;
    base = '0;
    base.soft_limit_positive = 8030;
    base.soft_limit_negative = -30;
    base.zone_bound_upper = 200;
    base.zone_bound_lower = 100;
    base.teach_jog_speed = 16'h012c;
    base.teach_inch_distance = 16'h0096;
    base.default_speed = 16'h0190;
    base.default_accel = 16'h012c;
    base.default_position_band = BAND_RST;
    base.homing_sensor_polarity = SENS_NO;
    base.speed_scale_percent = 8'h14;
    base.phase_detect_dir = 1'b1;
    base.phase_detect_time_ms = 16'h0003;
    base.manual_feed_speed = 16'h012c;
    base.servo_off_delay_a = 8'h01;
    base.servo_off_delay_b = 8'h02;
    base.servo_off_delay_c = 8'h03;
    rows[0] = '{0, 0, mk(AMPS_MOVE, 1, 0, 5000, 500, 10), 1, 5000, 100, 0};
    rows[1] = '{0, 0, mk(AMPS_MOVE, 0, 0, 5000, 500, 10), 1, 5000, 500, 0};
    rows[2] = '{0, 0, mk(AMPS_MOVE, 1, 0, 9000, 50, 10), 1, 8030, 10, 0};
    rows[3] = '{0, 0, mk(AMPS_MOVE, 0, 0, -500, 50, 10), 1, -30, 50, 0};
    rows[4] = '{0, 0, mk(AMPS_MOVE, 0, 1, 2000, 50, 10), 1, 2000, 250, 0};
    rows[5] = '{1, 0, mk(AMPS_JOG_POS, 1, 0, 0, 0, 0), 1, 8030, 250, 0};
    rows[6] = '{1, 0, mk(AMPS_INCH_POS, 1, 0, 0, 0, 0), 1, 1100, 250, 0};
    rows[7] = '{1, 0, mk(AMPS_INCH_NEG, 1, 0, 0, 0, 0), 1, 900, 250, 0};
    rows[8] = '{0, 0, mk(AMPS_JOG_POS, 1, 0, 0, 0, 0), 0, 0, 0, 0};
    rows[9] = '{0, 0, mk(AMPS_HOME, 1, 0, 0, 0, 0), 1, 1000, 0, 1};
    rows[10] = '{0, 1, mk(AMPS_HOME, 1, 0, 0, 0, 0), 1, 1000, 0, 1};
    wait_look(5);
    chk({zone, servo_on, full_servo, phase_act, mv, pos_done, homed, fv}, 0);
    @(posedge clk);
    rst_n <= 1'b1;
    amps_plc_model_inst.restart(base);
    servo_on_req <= 1'b1;
    wait_look(3);
    chk({phase_act, phase_dir}, 2'b11);
    wait_look(8);
    chk(phase_act, 1);
    wait_look(6);
    chk({phase_act, servo_on}, 2'b01);
    @(posedge clk);
    servo_on_req <= 1'b0;
    wait_look(2);
    chk(servo_on, 0);
    @(posedge clk);
    servo_on_req <= 1'b1;
    wait_look(2);
    chk({phase_act, servo_on}, 2'b01);
    chk(zone, 0);
    cur_pos <= 1000;
    foreach (rows[i]) begin
      base.parallel_io_pattern = rows[i].pat;
      base.homing_direction = rows[i].hdir;
      amps_plc_model_inst.restart(base);
      amps_plc_model_inst.issue(rows[i].c);
      #1;
      chk(mv, rows[i].ev);
      if (rows[i].ev) begin
        chk(mo.target, rows[i].et);
        if (rows[i].home) begin
          chk({mo.dir, mo.homing}, {rows[i].hdir, 1'b1});
          @(posedge clk);
          home_done <= 1'b1;
          @(posedge clk);
          home_done <= 1'b0;
        end else begin
          chk(mo.speed, rows[i].es);
        end
      end
    end
    @(posedge clk);
    cur_pos <= 150;
    for (int p = 5; p >= 0; p--) begin
      base.parallel_io_pattern = 3'(p);
      amps_plc_model_inst.restart(base);
      go_home();
      wait_look(2);
      chk({zone, homed}, {(p == 0 || p == 4 || p == 5), 1'b1});
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      cur_pos <= (k < 2) ? 99 + k : 198 + k;
      wait_look(2);
      chk(zone, (k == 1 || k == 2));
    end
    // Fill on unregistered write, on capture, and none on a registered entry
    @(posedge clk);
    tbl_write <= 1'b1;
    @(posedge clk);
    tbl_write <= 1'b0;
    #1;
    chk({fv, fo}, {1'b1, 1'b1, 16'h0190, 16'h012c, BAND_RST});
    @(posedge clk);
    tbl_capture <= 1'b1;
    @(posedge clk);
    tbl_capture <= 1'b0;
    #1;
    chk({fv, fo.speed_valid, fo.accel, fo.band}, {2'b10, 16'h012c, BAND_RST});
    @(posedge clk);
    {tbl_write, tbl_registered} <= 2'b11;
    @(posedge clk);
    {tbl_write, tbl_registered} <= 2'b00;
    #1;
    chk(fv, 0);
    amps_plc_model_inst.issue(mk(AMPS_MOVE, 0, 0, 3000, 50, 20));
    #1;
    chk(pos_done, 0);
    @(posedge clk);
    cur_pos <= 2975;
    wait_look(2);
    chk(pos_done, 0);
    @(posedge clk);
    cur_pos <= 2985;
    wait_look(2);
    chk(pos_done, 1);
    for (int p = 0; p < 3; p++) begin
      base.homing_sensor_polarity = 2'(p);
      amps_plc_model_inst.restart(base);
      for (int r = 0; r < 2; r++) begin
        @(posedge clk);
        sens_raw <= r[0];
        wait_look(2);
        chk(sens_hit, (p == 1) ? r[0] : ((p == 2) ? !r[0] : 1'b0));
      end
    end
    for (int i = 0; i < 7; i++) begin
      base.parallel_io_pattern = (i < 5) ? PAT_STANDARD : PAT_THREE;
      base.standstill_mode_default = (i < 5) ? 3'(i) : ((i == 5) ? SSM_OFF_A : SSM_FULL);
      amps_plc_model_inst.restart(base);
      go_home();
      amps_plc_model_inst.issue(mk(AMPS_MOVE, 1, 0, 2985, 50, 20));
      d = 10 * i;
      if (i >= 1 && i <= 3) begin
        wait_look(d - 2);
        chk(servo_on, 1);
        wait_look(7);
        chk(servo_on, 0);
        amps_plc_model_inst.issue(mk(AMPS_MOVE, 1, 0, 2985, 50, 20));
        #1;
        chk({servo_on, mv}, 2'b11);
      end else begin
        wait_look(40);
        chk({servo_on, full_servo}, {1'b1, i == 4 || i == 6});
      end
    end
    finish_test();
  end
endmodule : amps_supervisor_test
